// file: hw/tlic_core.sv
// Two-level interrupt controller: registers, pending flags and call sequencing
//
// Overview of operation
// - Fifteen sources, each set to low or high priority.
// - A valid source condition sets that source's pending flag.
// - Pending flags set regardless of individual or global enables.
// - Enabled pending source requests a long call after current instruction.
// - Disabled source with pending flag makes no request; execution continues.
// - Return from interrupt resumes the interrupted program flow.
// - Each source has its own independent enable bit.
// - Individual enables count only while global gate bit 7 is one.
// - Global gate at zero blocks every source.
// - Designated sources have pending flag cleared by hardware on vectoring.
// - Other sources keep the flag until software clears it.
// - Flag still set after return: re-enter after one more instruction.
// - Extended enable registers decoded at 0xe6 and 0xe7.
// - Extended priority registers decoded at 0xf3 and 0xf4.
// - Undefined addresses are reserved; they store nothing and read zero.
// - High preempts running low routine; running high is never preempted.
// - Simultaneous requests: higher level first, then fixed source order.
// - Requests decoded every clock; one detect plus four call cycles.
// - Equal or lower request waits for return plus one instruction.
`timescale 1ns/10ps
module tlic_core (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [tlic_pkg::SFR_W-1:0] sfr_wdata_i,
    output logic [tlic_pkg::SFR_W-1:0] sfr_rdata_o,
    output logic sfr_hit_o,
    input wire logic [tlic_pkg::NUM_SRC-1:0] src_evt_i,
    input wire logic [tlic_pkg::NUM_SRC-1:0] pend_set_i,
    input wire logic [tlic_pkg::NUM_SRC-1:0] pend_clr_i,
    input wire logic ext_int0_pin_i,
    input wire logic ext_int1_pin_i,
    input wire logic instr_done_i,
    input wire logic return_from_interrupt_i,
    output logic irq_call_o,
    output logic [tlic_pkg::VEC_W-1:0] vector_o,
    output logic irq_ack_o,
    output logic [tlic_pkg::IDX_W-1:0] ack_src_o,
    output logic [tlic_pkg::NUM_SRC-1:0] pend_o,
    output logic active_hi_o,
    output logic active_lo_o
);
    import tlic_pkg::*;

    // =========================================================
    // Register file
    logic [7:0] interrupt_enable_ff;
    logic [7:0] irq_priority_ff;
    logic [7:0] ext_pin_irq_config_ff;
    logic [7:0] ext_irq_enable_1_ff;
    logic [7:0] ext_irq_enable_2_ff;
    logic [7:0] ext_irq_priority_1_ff;
    logic [7:0] ext_irq_priority_2_ff;
    logic [7:0] rdata_ff;
    logic hit_ff;

    logic hit_ie_w;
    logic hit_ip_w;
    logic hit_cfg_w;
    logic hit_e1_w;
    logic hit_e2_w;
    logic hit_p1_w;
    logic hit_p2_w;
    logic hit_any_w;
    logic [7:0] rd_mux_w;

    assign hit_ie_w = (sfr_addr_i == ADDR_IE);
    assign hit_ip_w = (sfr_addr_i == ADDR_IP);
    assign hit_cfg_w = (sfr_addr_i == ADDR_PINCFG);
    assign hit_e1_w = (sfr_addr_i == ADDR_EXT_IRQ_ENABLE_1);
    assign hit_e2_w = (sfr_addr_i == ADDR_EXT_IRQ_ENABLE_2);
    assign hit_p1_w = (sfr_addr_i == ADDR_EXT_IRQ_PRIORITY_1);
    assign hit_p2_w = (sfr_addr_i == ADDR_EXT_IRQ_PRIORITY_2);
    assign hit_any_w = hit_ie_w | hit_ip_w | hit_cfg_w | hit_e1_w | hit_e2_w | hit_p1_w | hit_p2_w;

    // Reserved addresses fall through to zero and never store
    assign rd_mux_w = hit_ie_w ? interrupt_enable_ff :
                      hit_ip_w ? irq_priority_ff :
                      hit_cfg_w ? ext_pin_irq_config_ff :
                      hit_e1_w ? ext_irq_enable_1_ff :
                      hit_e2_w ? ext_irq_enable_2_ff :
                      hit_p1_w ? ext_irq_priority_1_ff :
                      hit_p2_w ? ext_irq_priority_2_ff : RD_UNMAPPED;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            interrupt_enable_ff <= REG_RST;
            irq_priority_ff <= REG_RST;
            ext_pin_irq_config_ff <= REG_RST;
            ext_irq_enable_1_ff <= REG_RST;
            ext_irq_enable_2_ff <= REG_RST;
            ext_irq_priority_1_ff <= REG_RST;
            ext_irq_priority_2_ff <= REG_RST;
        end else if (sfr_wr_i) begin
            if (hit_ie_w) interrupt_enable_ff <= sfr_wdata_i;
            if (hit_ip_w) irq_priority_ff <= sfr_wdata_i;
            if (hit_cfg_w) ext_pin_irq_config_ff <= sfr_wdata_i;
            if (hit_e1_w) ext_irq_enable_1_ff <= sfr_wdata_i;
            if (hit_e2_w) ext_irq_enable_2_ff <= sfr_wdata_i;
            if (hit_p1_w) ext_irq_priority_1_ff <= sfr_wdata_i;
            if (hit_p2_w) ext_irq_priority_2_ff <= sfr_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_ff <= RD_UNMAPPED;
            hit_ff <= 1'b0;
        end else if (sfr_rd_i) begin
            rdata_ff <= rd_mux_w;
            hit_ff <= hit_any_w;
        end
    end

    // =========================================================
    // External pins: edge in the configured direction is the event
    logic [NUM_EXT-1:0] pin_lvl_w;
    logic [NUM_EXT-1:0] pin_prev_ff;
    logic [NUM_EXT-1:0] pin_pol_w;
    logic [NUM_EXT-1:0] pin_edge_w;

    tlic_pin_sync u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .pin_i({ext_int1_pin_i, ext_int0_pin_i}),
        .level_o(pin_lvl_w)
    );

    assign pin_pol_w = {ext_pin_irq_config_ff[PIN1_POL_BIT], ext_pin_irq_config_ff[PIN0_POL_BIT]};
    // Previous level starts at zero like the synchroniser level, so reset never fakes an edge
    assign pin_edge_w = (pin_lvl_w ^ pin_prev_ff) & ~(pin_lvl_w ^ pin_pol_w);

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_prev_ff <= '0;
        end else begin
            pin_prev_ff <= pin_lvl_w;
        end
    end

    // =========================================================
    // Pending flags
    logic [NUM_SRC-1:0] pend_ff;
    logic [NUM_SRC-1:0] set_w;
    logic [NUM_SRC-1:0] hw_clr_w;
    logic [NUM_SRC-1:0] nxt_pend;
    logic [NUM_SRC-1:0] pin_set_w;

    assign pin_set_w = (NUM_SRC'(pin_edge_w[0]) << SRC_PIN0) | (NUM_SRC'(pin_edge_w[1]) << SRC_PIN1);
    // Events land no matter how the enables stand
    assign set_w = src_evt_i | pend_set_i | pin_set_w;
    // Set wins over any clear arriving in the same cycle
    assign nxt_pend = set_w | (pend_ff & ~pend_clr_i & ~hw_clr_w);

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_ff <= '0;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // =========================================================
    // Request gating and arbitration
    logic [NUM_SRC-1:0] en_w;
    logic [NUM_SRC-1:0] hi_w;
    logic gate_w;
    logic [NUM_SRC-1:0] req_w;
    logic sel_valid_w;
    logic sel_hi_w;
    logic [IDX_W-1:0] sel_idx_w;

    assign en_w = tlic_map(interrupt_enable_ff, ext_irq_enable_1_ff, ext_irq_enable_2_ff);
    assign hi_w = tlic_map(irq_priority_ff, ext_irq_priority_1_ff, ext_irq_priority_2_ff);
    assign gate_w = interrupt_enable_ff[GATE_BIT];
    assign req_w = pend_ff & en_w & {NUM_SRC{gate_w}};

    tlic_arbiter u_arbiter (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .req_i(req_w),
        .hi_i(hi_w),
        .sel_valid_o(sel_valid_w),
        .sel_hi_o(sel_hi_w),
        .sel_idx_o(sel_idx_w)
    );

    // =========================================================
    // Call sequencing and the in-service levels
    tlic_state_t state_ff;
    tlic_state_t nxt_state;
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic act_hi_ff;
    logic act_lo_ff;
    logic call_ff;
    logic ack_ff;
    logic [IDX_W-1:0] cur_idx_ff;
    logic cur_hi_ff;
    logic [VEC_W-1:0] vec_ff;
    logic may_preempt_w;
    logic start_w;
    logic last_w;
    logic pop_w;
    logic boundary_w;

    // A routine in service blocks its own and lower levels
    assign may_preempt_w = !act_hi_ff && (!act_lo_ff || sel_hi_w);
    // Only at an instruction boundary; return itself is not one
    assign boundary_w = (state_ff == ST_IDLE || state_ff == ST_RETW) && instr_done_i && !return_from_interrupt_i;
    assign start_w = boundary_w && sel_valid_w && may_preempt_w;
    assign last_w = (state_ff == ST_CALL) && (cnt_ff == CALL_LAST);
    assign pop_w = return_from_interrupt_i && (state_ff != ST_CALL);
    assign hw_clr_w = last_w ? (HW_CLR_MASK & (NUM_SRC'(1) << cur_idx_ff)) : '0;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (pop_w) begin
                    nxt_state = ST_RETW;
                end else if (start_w) begin
                    nxt_state = ST_CALL;
                    nxt_cnt = CNT_ZERO;
                end
            end
            ST_CALL: begin
                nxt_cnt = cnt_ff + CNT_ONE;
                if (last_w) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_RETW: begin
                if (pop_w) begin
                    nxt_state = ST_RETW;
                end else if (start_w) begin
                    nxt_state = ST_CALL;
                    nxt_cnt = CNT_ZERO;
                end else if (instr_done_i) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_cnt = CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= CNT_ZERO;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Latch the winner so the vector stays put through the call
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_idx_ff <= '0;
            cur_hi_ff <= 1'b0;
            vec_ff <= VEC_BASE;
        end else if (start_w) begin
            cur_idx_ff <= sel_idx_w;
            cur_hi_ff <= sel_hi_w;
            vec_ff <= tlic_vec(sel_idx_w);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            call_ff <= 1'b0;
            ack_ff <= 1'b0;
        end else begin
            call_ff <= (nxt_state == ST_CALL);
            ack_ff <= last_w;
        end
    end

    // Return drops the highest level in service first
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            act_hi_ff <= 1'b0;
            act_lo_ff <= 1'b0;
        end else if (last_w) begin
            if (cur_hi_ff) act_hi_ff <= 1'b1;
            else act_lo_ff <= 1'b1;
        end else if (pop_w) begin
            if (act_hi_ff) act_hi_ff <= 1'b0;
            else act_lo_ff <= 1'b0;
        end
    end

    // =========================================================
    // Outputs
    assign sfr_rdata_o = rdata_ff;
    assign sfr_hit_o = hit_ff;
    assign irq_call_o = call_ff;
    assign vector_o = vec_ff;
    assign irq_ack_o = ack_ff;
    assign ack_src_o = cur_idx_ff;
    assign pend_o = pend_ff;
    assign active_hi_o = act_hi_ff;
    assign active_lo_o = act_lo_ff;

    // =========================================================
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    logic [NUM_SRC-1:0] evt_any_w;
    assign evt_any_w = set_w;

    // Arbiter input one clock back, so its registered pick can be checked
    logic [NUM_SRC-1:0] req_q_ff;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_q_ff <= '0;
        end else begin
            req_q_ff <= req_w;
        end
    end

    gate_blocks_a: assert property (!gate_w |-> req_w == '0)
        else $error("request seen with global gate off");
    flag_sets_a: assert property (evt_any_w != '0 |=> (pend_ff & $past(evt_any_w)) == $past(evt_any_w))
        else $error("event did not set its pending flag");
    call_len_a: assert property ($rose(irq_call_o) |-> irq_call_o[*4] ##1 !irq_call_o)
        else $error("call phase not four cycles");
    ack_end_a: assert property ($rose(irq_call_o) |-> !irq_ack_o[*4] ##1 irq_ack_o)
        else $error("vector acknowledge misplaced");
    hw_clear_a: assert property (irq_ack_o && HW_CLR_MASK[ack_src_o] && !$past(evt_any_w[ack_src_o])
        |-> !pend_ff[ack_src_o])
        else $error("hardware-cleared flag still set");
    sw_keep_a: assert property (irq_ack_o && !HW_CLR_MASK[ack_src_o] && !$past(pend_clr_i[ack_src_o])
        |-> pend_ff[ack_src_o])
        else $error("software-cleared flag dropped by vectoring");
    hi_no_preempt_a: assert property (act_hi_ff && state_ff != ST_CALL |=> !$rose(irq_call_o))
        else $error("high routine preempted");
    return_from_interrupt_wait_a: assert property (pop_w |=> !irq_call_o)
        else $error("call started before following instruction");
    start_enabled_a: assert property (start_w |-> req_q_ff[sel_idx_w])
        else $error("call for a source without request");
    vec_map_a: assert property ($rose(irq_call_o) |-> vector_o == tlic_vec(ack_src_o))
        else $error("vector does not match source");

    call_seen_c: cover property ($rose(irq_call_o));
    preempt_c: cover property (act_lo_ff && $rose(irq_call_o) && cur_hi_ff);
    reenter_c: cover property (pop_w ##[1:20] $rose(irq_call_o));
    reserved_rd_c: cover property (sfr_rd_i && !hit_any_w);
endmodule // tlic_core

// file: shared/tlic_pkg.sv
// Shared constants, types and helpers of the two-level interrupt controller
package tlic_pkg;

    // =========================================================
    // Sizes
    localparam int NUM_SRC = 15;
    localparam int NUM_EXT = 2;
    localparam int IDX_W = 4;
    localparam int VEC_W = 16;
    localparam int SFR_W = 8;

    // =========================================================
    // Special function register addresses
    localparam logic [7:0] ADDR_IE = 8'ha8;
    localparam logic [7:0] ADDR_IP = 8'hb8;
    localparam logic [7:0] ADDR_PINCFG = 8'he4;
    localparam logic [7:0] ADDR_EXT_IRQ_ENABLE_1 = 8'he6;
    localparam logic [7:0] ADDR_EXT_IRQ_ENABLE_2 = 8'he7;
    localparam logic [7:0] ADDR_EXT_IRQ_PRIORITY_1 = 8'hf3;
    localparam logic [7:0] ADDR_EXT_IRQ_PRIORITY_2 = 8'hf4;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // =========================================================
    // Field positions
    localparam int GATE_BIT = 7;
    localparam int IE_SRC_N = 7;
    localparam int E1_SRC_N = 6;
    localparam int E2_SRC_N = 2;
    localparam int PIN0_POL_BIT = 3;
    localparam int PIN1_POL_BIT = 7;
    localparam int SRC_PIN0 = 0;
    localparam int SRC_PIN1 = 2;

    // Sources whose pending flag is dropped by hardware on vectoring
    localparam logic [NUM_SRC-1:0] HW_CLR_MASK = 15'h000f;

    // =========================================================
    // Vectoring and timing
    localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
    localparam int VEC_SHIFT = 3;
    localparam int ORDER_GAP_AT = 13;
    localparam int ORDER_GAP = 2;
    localparam int CALL_CYCLES = 4;
    localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);
    localparam logic [2:0] CNT_ZERO = 3'h0;
    localparam logic [2:0] CNT_ONE = 3'h1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CALL = 2'b01,
        ST_RETW = 2'b10
    } tlic_state_t;

    // Gather three enable or priority registers into one bit per source
    function automatic logic [NUM_SRC-1:0] tlic_map(input logic [7:0] r0, input logic [7:0] r1,
                                                    input logic [7:0] r2);
        return {r2[E2_SRC_N-1:0], r1[E1_SRC_N-1:0], r0[IE_SRC_N-1:0]};
    endfunction

    // Service address of a source, skipping the two unused order slots
    function automatic logic [VEC_W-1:0] tlic_vec(input logic [IDX_W-1:0] idx);
        logic [VEC_W-1:0] ord;
        ord = VEC_W'(idx);
        if (idx >= IDX_W'(ORDER_GAP_AT)) begin
            ord = ord + VEC_W'(ORDER_GAP);
        end
        return VEC_BASE + (ord << VEC_SHIFT);
    endfunction

endpackage

// file: hw/tlic_pin_sync.sv
// Three-stage synchroniser and agreement filter for the external interrupt pins
`timescale 1ns/10ps
module tlic_pin_sync (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [tlic_pkg::NUM_EXT-1:0] pin_i,
    output logic [tlic_pkg::NUM_EXT-1:0] level_o
);
    import tlic_pkg::*;

    // =========================================================
    // Sync chain; stage one feeds only stage two
    logic [NUM_EXT-1:0] s1_ff;
    logic [NUM_EXT-1:0] s2_ff;
    logic [NUM_EXT-1:0] s3_ff;
    logic [NUM_EXT-1:0] lvl_ff;
    logic [NUM_EXT-1:0] agree_w;
    logic [NUM_EXT-1:0] nxt_lvl;

    assign agree_w = ~(s2_ff ^ s3_ff);
    assign nxt_lvl = (agree_w & s3_ff) | (~agree_w & lvl_ff);

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            lvl_ff <= '0;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    assign level_o = lvl_ff;
endmodule // tlic_pin_sync

// file: hw/tlic_arbiter.sv
// Registered two-level priority picker; its register is the detect cycle
`timescale 1ns/10ps
module tlic_arbiter (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [tlic_pkg::NUM_SRC-1:0] req_i,
    input wire logic [tlic_pkg::NUM_SRC-1:0] hi_i,
    output logic sel_valid_o,
    output logic sel_hi_o,
    output logic [tlic_pkg::IDX_W-1:0] sel_idx_o
);
    import tlic_pkg::*;

    // Lowest index wins inside one level
    function automatic logic [IDX_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IDX_W'(i);
            end
        end
        return r;
    endfunction

    // =========================================================
    // Level first, then fixed order
    logic [NUM_SRC-1:0] hi_req_w;
    logic any_hi_w;
    logic [IDX_W-1:0] nxt_idx;
    logic valid_ff;
    logic hi_ff;
    logic [IDX_W-1:0] idx_ff;

    assign hi_req_w = req_i & hi_i;
    assign any_hi_w = |hi_req_w;
    assign nxt_idx = any_hi_w ? first_set(hi_req_w) : first_set(req_i);

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            valid_ff <= 1'b0;
            hi_ff <= 1'b0;
            idx_ff <= '0;
        end else begin
            valid_ff <= |req_i;
            hi_ff <= any_hi_w;
            idx_ff <= nxt_idx;
        end
    end

    assign sel_valid_o = valid_ff;
    assign sel_hi_o = hi_ff;
    assign sel_idx_o = idx_ff;
endmodule // tlic_arbiter

// file: testbench/tlic_cpu_model.sv
// Behavioural CPU core: retires instructions and returns from service routines
`timescale 1ns/10ps
module tlic_cpu_model (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic slow_i,
    input wire logic call_i,
    input wire logic return_from_interrupt_req_i,
    output logic instr_done_o,
    output logic return_from_interrupt_o
);
    int cnt = 0;
    logic take_return_from_interrupt;
    logic in_call;
    initial begin
        instr_done_o = 1'b0;
        return_from_interrupt_o = 1'b0;
    end
    // =========================================================
    // Sample on the edge, drive just after it
    always @(posedge ref_clk_i) begin
        take_return_from_interrupt = return_from_interrupt_req_i;
        in_call = call_i;
        #1;
        cnt = (cnt + 1) % 4;
        return_from_interrupt_o = rstn_i && take_return_from_interrupt;
        // Nothing retires in the return cycle or during the call, so re-entry waits one instruction
        instr_done_o = rstn_i && !take_return_from_interrupt && !in_call && (!slow_i || cnt == 0);
    end
endmodule // tlic_cpu_model

// file: testbench/tb_top.sv
// Self-checking bench of the interrupt controller against a behavioural model
`timescale 1ns/10ps
module tb_top;
    import tlic_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [14:0] evt = '0;
    logic [14:0] pset = '0;
    logic [14:0] pclr = '0;
    logic pin0 = 1'b0;
    logic pin1 = 1'b1;
    logic slow = 1'b0;
    logic return_from_interrupt_req = 1'b0;
    logic instr_done, return_from_interrupt, hit, call, ack, act_hi, act_lo;
    logic [7:0] rdata;
    logic [15:0] vec;
    logic [3:0] ack_src;
    logic [14:0] pend;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 1902;
    logic [7:0] m_reg [0:255];
    logic [14:0] m_pend = '0;
    logic [7:0] map_q [$] = '{ADDR_IE, ADDR_IP, ADDR_PINCFG, ADDR_EXT_IRQ_ENABLE_1, ADDR_EXT_IRQ_ENABLE_2, ADDR_EXT_IRQ_PRIORITY_1, ADDR_EXT_IRQ_PRIORITY_2};

    always #5 ref_clk_i = ~ref_clk_i;

    tlic_core i_tlic_core (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sfr_hit_o(hit), .src_evt_i(evt),
        .pend_set_i(pset), .pend_clr_i(pclr), .ext_int0_pin_i(pin0), .ext_int1_pin_i(pin1),
        .instr_done_i(instr_done), .return_from_interrupt_i(return_from_interrupt), .irq_call_o(call), .vector_o(vec), .irq_ack_o(ack),
        .ack_src_o(ack_src), .pend_o(pend), .active_hi_o(act_hi), .active_lo_o(act_lo));
    tlic_cpu_model i_tlic_cpu_model (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .slow_i(slow), .call_i(call),
        .return_from_interrupt_req_i(return_from_interrupt_req), .instr_done_o(instr_done), .return_from_interrupt_o(return_from_interrupt));

    // =========================================================
    // Model helpers
    function automatic int xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [14:0] m_map(logic [7:0] a, logic [7:0] b, logic [7:0] c);
        return {c[1:0], b[5:0], a[6:0]};
    endfunction
    // High level first, then lowest index
    function automatic int m_win();
        logic [14:0] req;
        logic [14:0] hi;
        int w;
        req = m_pend & m_map(m_reg[8'ha8], m_reg[8'he6], m_reg[8'he7]) & {15{m_reg[8'ha8][7]}};
        hi = m_map(m_reg[8'hb8], m_reg[8'hf3], m_reg[8'hf4]);
        w = -1;
        for (int i = 14; i >= 0; i--) if (req[i]) w = i;
        for (int i = 14; i >= 0; i--) if (req[i] && hi[i]) w = i;
        return w;
    endfunction
    function automatic logic [15:0] m_vec(int i);
        return 16'(3 + 8 * (i < 13 ? i : i + 2));
    endfunction

    // =========================================================
    // Bus and check tasks
    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic sfr_w(logic [7:0] a, logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        if (a inside {map_q}) m_reg[a] = d;
        tick();
        wr = 1'b0;
        tick();
    endtask
    task automatic sfr_r(logic [7:0] a);
        addr = a;
        rd = 1'b1;
        tick();
        rd = 1'b0;
        check(16'(rdata), a inside {map_q} ? 16'(m_reg[a]) : 16'h0000);
        check(16'(hit), 16'(a inside {map_q}));
        tick();
    endtask
    // Set wins over clear, as in the design
    task automatic fire(logic [14:0] e, logic [14:0] s, logic [14:0] c);
        evt = e;
        pset = s;
        pclr = c;
        m_pend = (m_pend & ~c) | e | s;
        tick();
        evt = '0;
        pset = '0;
        pclr = '0;
        tick();
    endtask
    task automatic serve(int idx, int lat);
        int n;
        n = 0;
        while (call !== 1'b1 && n < 60) begin
            tick();
            n++;
        end
        if (lat >= 0) check(16'(n), 16'(lat));
        check(vec, m_vec(idx));
        check(16'(ack_src), 16'(idx));
        n = 0;
        while (call === 1'b1 && n < 9) begin
            tick();
            n++;
        end
        check(16'(n), 16'(CALL_CYCLES));
        check(16'(ack), 16'h0001);
        if (idx < 4) m_pend[idx] = 1'b0;
        tick();
        check(16'(pend), 16'(m_pend));
    endtask
    task automatic do_return_from_interrupt();
        return_from_interrupt_req = 1'b1;
        tick();
        return_from_interrupt_req = 1'b0;
        tick();
    endtask
    task automatic quiet(int n);
        int seen;
        seen = 0;
        repeat (n) begin
            tick();
            if (call !== 1'b0) seen++;
        end
        check(16'(seen), 16'h0000);
    endtask
    task automatic wrap_up();
        $display("compared=%0d mismatches=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Run is under 1000 cycles; the 20000 ceiling leaves ample margin
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles >= 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    // =========================================================
    // Scenarios
    initial begin
        for (int i = 0; i < 256; i++) m_reg[i] = 8'h00;
        repeat (20) @(posedge ref_clk_i);
        #1;
        rstn_i = 1'b1;
        tick();
        foreach (map_q[i]) sfr_r(map_q[i]);
        foreach (map_q[i]) begin
            sfr_w(map_q[i], 8'(xs()) & 8'h77);
            sfr_r(map_q[i]);
        end
        sfr_w(8'he5, 8'(xs()));
        sfr_r(8'he5);
        foreach (map_q[i]) sfr_w(map_q[i], 8'h00);
        sfr_w(ADDR_IE, 8'h7f);
        sfr_w(ADDR_EXT_IRQ_ENABLE_1, 8'h3f);
        sfr_w(ADDR_EXT_IRQ_ENABLE_2, 8'h03);
        fire(15'(xs()) | 15'h0010, '0, '0);
        quiet(12);
        check(16'(pend), 16'(m_pend));
        fire('0, '0, 15'h7fff);
        sfr_w(ADDR_PINCFG, 8'h08);
        pin0 = 1'b1;
        pin1 = 1'b0;
        m_pend = 15'h0005;
        repeat (8) tick();
        check(16'(pend), 16'(m_pend));
        fire('0, '0, 15'h0005);
        sfr_w(ADDR_IE, 8'hff);
        for (int i = 0; i < 15; i++) begin
            slow = i[0];
            if (i[0]) fire('0, 15'(1) << i, '0);
            else fire(15'(1) << i, '0, '0);
            serve(m_win(), i[0] ? -1 : 1);
            if (i >= 4) begin
                do_return_from_interrupt();
                serve(i, -1);
                fire('0, '0, 15'(1) << i);
            end
            do_return_from_interrupt();
            quiet(10);
        end
        slow = 1'b0;
        sfr_w(ADDR_EXT_IRQ_ENABLE_1, 8'h3e);
        sfr_w(ADDR_EXT_IRQ_PRIORITY_1, 8'h04);
        fire(15'h02a0, '0, '0);
        serve(9, -1);
        check(16'({act_hi, act_lo}), 16'h0002);
        quiet(10);
        fire('0, '0, 15'h0200);
        do_return_from_interrupt();
        serve(5, -1);
        fire(15'h0200, '0, '0);
        serve(9, -1);
        check(16'({act_hi, act_lo}), 16'h0003);
        fire('0, '0, 15'h0220);
        do_return_from_interrupt();
        do_return_from_interrupt();
        quiet(10);
        check(16'(pend), 16'(m_pend));
        check(16'({act_hi, act_lo}), 16'h0000);
        wrap_up();
    end
endmodule // tb_top
